//--- hdl/pbvf_cfg.svh
`ifndef PBVF_CFG_SVH
`define PBVF_CFG_SVH

// register byte addresses
`define PBVF_OFF_CTRL 9'h000
`define PBVF_OFF_STATUS 9'h004
`define PBVF_OFF_VFCNT 9'h008
`define PBVF_OFF_DELTA 9'h00C
`define PBVF_OFF_CAP 9'h010
`define PBVF_OFF_PAGE 9'h020
`define PBVF_OFF_BARCFG 9'h040
`define PBVF_OFF_BASE 9'h080
`define PBVF_OFF_EFF 9'h100

// slot layout: six function slots, expansion rom, six virtual-function slots
`define PBVF_NUM_SLOTS 13
`define PBVF_ROM_SLOT 6
`define PBVF_VF_SLOT0 7

// control word fields
`define PBVF_CTRL_MODE_LSB 0
`define PBVF_CTRL_ARI_BIT 2
`define PBVF_CTRL_HIGH_BIT 3

// bar configuration word fields
`define PBVF_CFG_EN_BIT 0
`define PBVF_CFG_IO_BIT 1
`define PBVF_CFG_64_BIT 2
`define PBVF_CFG_PREF_BIT 3
`define PBVF_CFG_SIZE_LSB 8

// capability word fields
`define PBVF_CAP_VER_LSB 0
`define PBVF_CAP_DEP_LSB 8
`define PBVF_CAP_DEVID_LSB 16

// reset values
`define PBVF_RST_CAP 32'h0000_0001
`define PBVF_RST_PAGE 32'h0000_0001

// aperture limits as log2 of bytes
`define PBVF_SZ_16B 6'h04
`define PBVF_SZ_128B 6'h07
`define PBVF_SZ_2KB 6'h0B
`define PBVF_SZ_2GB 6'h1F
`define PBVF_SZ_4GB 6'h20
`define PBVF_SZ_256GB 6'h26
`define PBVF_SZ_8EB 6'h3F

// virtual function numbering
`define PBVF_VF_START_LOW 8'h04
`define PBVF_VF_START_HIGH 8'h40
`define PBVF_VF_START_NOARI 8'h01
`define PBVF_NOARI_MAX_VFS 11'h007
`define PBVF_LAST_FN 11'h0FF

`endif

//--- hdl/pbvf_pkg.sv
package pbvf_pkg;
   typedef enum logic [1:0] {PBVF_EP, PBVF_LEGACY, PBVF_ROOT} pbvf_mode_e;

   typedef struct packed {
      logic en;
      logic io;
      logic is64;
      logic pref;
      logic [5:0] sizeLog2;
   } pbvf_bar_s;

   typedef struct packed {
      logic [63:0] addr;
      logic io;
      logic vfBank;
   } pbvf_req_s;
endpackage

//--- hdl/pbvf_bar_match.sv
`timescale 1ns/1ps
`default_nettype none
module pbvf_bar_match
   import pbvf_pkg::*;
(
   // legalized slot setting and programmed base
   input wire pbvf_bar_s cfg,
   input wire logic [63:0] base,
   // request
   input wire logic [63:0] addr,
   input wire logic io,
   // result
   output logic hit
);
   logic [63:0] mask;
   logic upperOk;

   // offset bits below the aperture are ignored in the compare
   assign mask = ~((64'h0000_0000_0000_0001 << cfg.sizeLog2) - 64'h0000_0000_0000_0001);
   // a 32-bit slot only sees the low 4 GB
   assign upperOk = cfg.is64 || (addr[63:32] == 32'h0000_0000);
   // disabled slot decodes nothing; space type must agree
   assign hit = cfg.en && (cfg.io == io) && upperOk && (((addr ^ base) & mask) == 64'h0);
endmodule
`default_nettype wire

//--- hdl/pbvf_vf_map.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbvf_cfg.svh"
module pbvf_vf_map
   import pbvf_pkg::*;
#(
   parameter int MAX_VFS = 252
) (
   // layout setting
   input wire logic ari,
   input wire logic highStart,
   input wire logic [3:0][7:0] vfCount,
   // function lookup
   input wire logic [7:0] fnNum,
   // layout results
   output logic [7:0] globalStart,
   output logic [3:0][7:0] startDelta,
   output logic [10:0] totalVfs,
   output logic layoutOk,
   // lookup results
   output logic fnOk,
   output logic fnIsVf,
   output logic [1:0] fnOwner,
   output logic [7:0] fnVfIdx
);
   if (MAX_VFS < 1 || MAX_VFS > 252) begin : g_bad_max
      $error("pbvf_vf_map: MAX_VFS out of range");
   end

   logic [10:0] cum;
   logic [10:0] first;
   logic [10:0] eff;
   logic [10:0] fnWide;

   // global start, per-function deltas and owner search in one pass
   always_comb begin
      cum = 11'h000;
      first = 11'h000;
      eff = 11'h000;
      fnWide = {3'h0, fnNum};
      globalStart = ari ? (highStart ? `PBVF_VF_START_HIGH : `PBVF_VF_START_LOW)
                        : `PBVF_VF_START_NOARI;
      startDelta = '0;
      fnIsVf = 1'b0;
      fnVfIdx = 8'h00;
      // physical functions sit at fixed numbers; without ari only one exists
      fnOk = ari ? (fnNum < 8'h04) : (fnNum == 8'h00);
      fnOwner = fnNum[1:0];
      for (int k = 0; k < 4; k++) begin
         if (ari) begin
            eff = {3'h0, vfCount[k]};
         end else if (k == 0) begin
            eff = ({3'h0, vfCount[0]} > `PBVF_NOARI_MAX_VFS) ? `PBVF_NOARI_MAX_VFS
                                                              : {3'h0, vfCount[0]};
         end else begin
            eff = 11'h000;
         end
         // each function's vfs follow the previous function's block
         first = {3'h0, globalStart} + cum;
         startDelta[k] = 8'(first - 11'(k));
         if (eff != 11'h000 && fnWide >= first && fnWide < first + eff) begin
            fnOk = 1'b1;
            fnIsVf = 1'b1;
            fnOwner = 2'(k);
            fnVfIdx = 8'(fnWide - first);
         end
         cum = cum + eff;
      end
      totalVfs = cum;
      // last vf number must stay inside the 8-bit function space
      layoutOk = (cum <= 11'(MAX_VFS)) &&
                 ((cum == 11'h000) || ({3'h0, globalStart} + cum - 11'h001 <= `PBVF_LAST_FN));
      // an illegal layout exposes no virtual functions at all
      if (fnIsVf && !layoutOk) begin
         fnOk = 1'b0;
      end
   end
endmodule
`default_nettype wire

//--- hdl/pbvf_top.sv
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pbvf_cfg.svh"
module pbvf_top
   import pbvf_pkg::*;
#(
   parameter int MAX_VFS = 252
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [8:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   // address decode request and answer
   input wire logic reqValid,
   input wire pbvf_req_s req,
   output logic reqHit,
   output logic [3:0] reqSlot,
   output logic reqMergeOk,
   // function number lookup
   input wire logic fnValid,
   input wire logic [7:0] fnNum,
   output logic fnHit,
   output logic fnIsVf,
   output logic [1:0] fnOwner,
   output logic [7:0] fnVfIdx,
   output logic [15:0] fnDevId
);
   localparam int NS = `PBVF_NUM_SLOTS;

   pbvf_mode_e mode_ff;
   logic ari_ff;
   logic highStart_ff;
   logic [3:0][7:0] vfCount_ff;
   logic [31:0] cap_ff [4];
   logic [31:0] page_ff [4];
   pbvf_bar_s barCfg_ff [NS];
   logic [63:0] base_ff [NS];
   pbvf_bar_s effCfg [NS];
   logic [NS-1:0] slotHit;
   logic [31:0] nxt_regRdata;
   logic [31:0] regRdata_ff;
   logic reqHit_ff;
   logic [3:0] reqSlot_ff;
   logic reqMergeOk_ff;
   logic fnHit_ff;
   logic fnIsVf_ff;
   logic [1:0] fnOwner_ff;
   logic [7:0] fnVfIdx_ff;
   logic [15:0] fnDevId_ff;
   logic [7:0] globalStart;
   logic [3:0][7:0] startDelta;
   logic [10:0] totalVfs;
   logic layoutOk;
   logic mapOk;
   logic mapIsVf;
   logic [1:0] mapOwner;
   logic [7:0] mapVfIdx;
   logic [8:0] cfgOff;
   logic [8:0] baseOff;
   logic [8:0] effOff;
   logic isCfg;
   logic isBase;
   logic isEff;
   logic [3:0] cfgIdx;
   logic [3:0] baseIdx;
   logic [3:0] effIdx;

   // register address decode
   assign cfgOff = regAddr - `PBVF_OFF_BARCFG;
   assign baseOff = regAddr - `PBVF_OFF_BASE;
   assign effOff = regAddr - `PBVF_OFF_EFF;
   assign cfgIdx = cfgOff[5:2];
   assign baseIdx = baseOff[6:3];
   assign effIdx = effOff[5:2];
   assign isCfg = (regAddr >= `PBVF_OFF_BARCFG) && (cfgOff < 9'(NS * 4)) && (regAddr[1:0] == 2'h0);
   assign isBase = (regAddr >= `PBVF_OFF_BASE) && (baseOff < 9'(NS * 8)) && (regAddr[1:0] == 2'h0);
   assign isEff = (regAddr >= `PBVF_OFF_EFF) && (effOff < 9'(NS * 4)) && (regAddr[1:0] == 2'h0);

   // pack a slot setting into its register word
   function automatic logic [31:0] cfgWord(input pbvf_bar_s c);
      cfgWord = 32'h0000_0000;
      cfgWord[`PBVF_CFG_EN_BIT] = c.en;
      cfgWord[`PBVF_CFG_IO_BIT] = c.io;
      cfgWord[`PBVF_CFG_64_BIT] = c.is64;
      cfgWord[`PBVF_CFG_PREF_BIT] = c.pref;
      cfgWord[`PBVF_CFG_SIZE_LSB +: 6] = c.sizeLog2;
   endfunction

   // control word; an unused mode code leaves the mode unchanged
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_ff <= PBVF_EP;
         ari_ff <= 1'b1;
         highStart_ff <= 1'b0;
      end else if (regWr && regAddr == `PBVF_OFF_CTRL) begin
         case (regWdata[`PBVF_CTRL_MODE_LSB +: 2])
            2'h0: mode_ff <= PBVF_EP;
            2'h1: mode_ff <= PBVF_LEGACY;
            2'h2: mode_ff <= PBVF_ROOT;
            default: mode_ff <= mode_ff;
         endcase
         ari_ff <= regWdata[`PBVF_CTRL_ARI_BIT];
         highStart_ff <= regWdata[`PBVF_CTRL_HIGH_BIT];
      end
   end

   // vf counts per physical function
   always_ff @(posedge clk) begin
      if (rst) begin
         vfCount_ff <= '0;
      end else if (regWr && regAddr == `PBVF_OFF_VFCNT) begin
         vfCount_ff <= regWdata;
      end
   end

   // capability words (version, dependency link, vf device id) and page masks
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int k = 0; k < 4; k++) begin
            cap_ff[k] <= `PBVF_RST_CAP;
            page_ff[k] <= `PBVF_RST_PAGE;
         end
      end else if (regWr && regAddr[8:4] == 5'(`PBVF_OFF_CAP >> 4)) begin
         // reserved bits of the capability word are dropped
         cap_ff[regAddr[3:2]] <= regWdata & 32'hFFFF_FF0F;
      end else if (regWr && regAddr[8:4] == 5'(`PBVF_OFF_PAGE >> 4)) begin
         page_ff[regAddr[3:2]] <= regWdata;
      end
   end

   // raw slot settings as software wrote them
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int s = 0; s < NS; s++) begin
            barCfg_ff[s] <= '0;
         end
      end else if (regWr && isCfg) begin
         barCfg_ff[cfgIdx].en <= regWdata[`PBVF_CFG_EN_BIT];
         barCfg_ff[cfgIdx].io <= regWdata[`PBVF_CFG_IO_BIT];
         barCfg_ff[cfgIdx].is64 <= regWdata[`PBVF_CFG_64_BIT];
         barCfg_ff[cfgIdx].pref <= regWdata[`PBVF_CFG_PREF_BIT];
         barCfg_ff[cfgIdx].sizeLog2 <= regWdata[`PBVF_CFG_SIZE_LSB +: 6];
      end
   end

   // programmed base addresses, low and high words
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int s = 0; s < NS; s++) begin
            base_ff[s] <= 64'h0;
         end
      end else if (regWr && isBase) begin
         if (baseOff[2]) begin
            base_ff[baseIdx][63:32] <= regWdata;
         end else begin
            base_ff[baseIdx][31:0] <= regWdata;
         end
      end
   end

   // legalize every slot; slots settle in order so a wide slot can claim the next
   always_comb begin
      pbvf_bar_s c;
      int pos;
      logic vfb;
      logic [5:0] lo;
      logic [5:0] hi;
      c = '0;
      pos = 0;
      vfb = 1'b0;
      lo = 6'h00;
      hi = 6'h00;
      for (int s = 0; s < NS; s++) begin
         c = barCfg_ff[s];
         vfb = (s >= `PBVF_VF_SLOT0);
         pos = vfb ? s - `PBVF_VF_SLOT0 : s;
         if (s == `PBVF_ROM_SLOT) begin
            c.io = 1'b0;
            c.is64 = 1'b0;
            c.pref = 1'b0;
            lo = `PBVF_SZ_2KB;
            hi = `PBVF_SZ_4GB;
         end else begin
            if (pos != 0 && effCfg[s-1].en && effCfg[s-1].is64) begin
               c.en = 1'b0;
            end
            if (mode_ff == PBVF_ROOT && pos >= 2) begin
               c.en = 1'b0;
            end
            if (c.io && mode_ff != PBVF_LEGACY) begin
               c.en = 1'b0;
            end
            if (c.io) begin
               c.is64 = 1'b0;
               c.pref = 1'b0;
            end else if (mode_ff == PBVF_EP && c.pref && pos != 5) begin
               c.is64 = 1'b1;
            end
            // a wide slot needs a partner slot above it
            if (pos == 5 || (mode_ff == PBVF_ROOT && pos == 1)) begin
               c.is64 = 1'b0;
            end
            if (c.io) begin
               lo = `PBVF_SZ_16B;
            end else if (vfb) begin
               lo = c.is64 ? `PBVF_SZ_128B : `PBVF_SZ_16B;
            end else begin
               lo = (mode_ff == PBVF_EP) ? `PBVF_SZ_128B : `PBVF_SZ_16B;
            end
            // 3 GB is no power of two, so 32-bit vf slots top out at 2 GB
            if (!c.is64) begin
               hi = `PBVF_SZ_2GB;
            end else begin
               hi = vfb ? `PBVF_SZ_256GB : `PBVF_SZ_8EB;
            end
         end
         if (c.sizeLog2 < lo) begin
            c.sizeLog2 = lo;
         end else if (c.sizeLog2 > hi) begin
            c.sizeLog2 = hi;
         end
         effCfg[s] = c;
      end
   end

   // one comparator per slot
   for (genvar g = 0; g < NS; g++) begin : g_match
      pbvf_bar_match u_match (
         .cfg(effCfg[g]),
         .base(base_ff[g]),
         .addr(req.addr),
         .io(req.io),
         .hit(slotHit[g])
      );
   end

   // answer one cycle after the request; the lowest slot of the bank wins
   always_ff @(posedge clk) begin
      if (rst) begin
         reqHit_ff <= 1'b0;
         reqSlot_ff <= 4'h0;
         reqMergeOk_ff <= 1'b0;
      end else begin
         reqHit_ff <= 1'b0;
         reqSlot_ff <= 4'h0;
         reqMergeOk_ff <= 1'b0;
         if (reqValid) begin
            for (int s = NS - 1; s >= 0; s--) begin
               if (slotHit[s] && (req.vfBank == (s >= `PBVF_VF_SLOT0))) begin
                  reqHit_ff <= 1'b1;
                  reqSlot_ff <= 4'(s);
                  reqMergeOk_ff <= effCfg[s].pref && !effCfg[s].io;
               end
            end
         end
      end
   end

   // virtual function numbering
   pbvf_vf_map #(
      .MAX_VFS(MAX_VFS)
   ) u_map (
      .ari(ari_ff),
      .highStart(highStart_ff),
      .vfCount(vfCount_ff),
      .fnNum(fnNum),
      .globalStart(globalStart),
      .startDelta(startDelta),
      .totalVfs(totalVfs),
      .layoutOk(layoutOk),
      .fnOk(mapOk),
      .fnIsVf(mapIsVf),
      .fnOwner(mapOwner),
      .fnVfIdx(mapVfIdx)
   );

   // function lookup answer; a vf reports its owner's shared device id
   always_ff @(posedge clk) begin
      if (rst) begin
         fnHit_ff <= 1'b0;
         fnIsVf_ff <= 1'b0;
         fnOwner_ff <= 2'h0;
         fnVfIdx_ff <= 8'h00;
         fnDevId_ff <= 16'h0000;
      end else begin
         fnHit_ff <= fnValid && mapOk;
         fnIsVf_ff <= fnValid && mapOk && mapIsVf;
         fnOwner_ff <= mapOwner;
         fnVfIdx_ff <= mapVfIdx;
         fnDevId_ff <= (fnValid && mapOk && mapIsVf)
                       ? cap_ff[mapOwner][`PBVF_CAP_DEVID_LSB +: 16] : 16'h0000;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      nxt_regRdata = 32'h0000_0000;
      if (regAddr == `PBVF_OFF_CTRL) begin
         nxt_regRdata[`PBVF_CTRL_MODE_LSB +: 2] = mode_ff;
         nxt_regRdata[`PBVF_CTRL_ARI_BIT] = ari_ff;
         nxt_regRdata[`PBVF_CTRL_HIGH_BIT] = highStart_ff;
      end else if (regAddr == `PBVF_OFF_STATUS) begin
         nxt_regRdata = {globalStart, 5'h00, totalVfs, 7'h00, layoutOk};
      end else if (regAddr == `PBVF_OFF_VFCNT) begin
         nxt_regRdata = vfCount_ff;
      end else if (regAddr == `PBVF_OFF_DELTA) begin
         nxt_regRdata = startDelta;
      end else if (regAddr[8:4] == 5'(`PBVF_OFF_CAP >> 4) && regAddr[1:0] == 2'h0) begin
         nxt_regRdata = cap_ff[regAddr[3:2]];
      end else if (regAddr[8:4] == 5'(`PBVF_OFF_PAGE >> 4) && regAddr[1:0] == 2'h0) begin
         nxt_regRdata = page_ff[regAddr[3:2]];
      end else if (isCfg) begin
         nxt_regRdata = cfgWord(barCfg_ff[cfgIdx]);
      end else if (isBase) begin
         nxt_regRdata = baseOff[2] ? base_ff[baseIdx][63:32] : base_ff[baseIdx][31:0];
      end else if (isEff) begin
         nxt_regRdata = cfgWord(effCfg[effIdx]);
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (rst) begin
         regRdata_ff <= 32'h0000_0000;
      end else begin
         regRdata_ff <= regRd ? nxt_regRdata : 32'h0000_0000;
      end
   end

   // outputs straight from flops
   assign regRdata = regRdata_ff;
   assign reqHit = reqHit_ff;
   assign reqSlot = reqSlot_ff;
   assign reqMergeOk = reqMergeOk_ff;
   assign fnHit = fnHit_ff;
   assign fnIsVf = fnIsVf_ff;
   assign fnOwner = fnOwner_ff;
   assign fnVfIdx = fnVfIdx_ff;
   assign fnDevId = fnDevId_ff;

   // helpers read only by the checks below
   logic anyBankHit;
   logic ioBad;
   logic wideBad;
   logic prefBad;
   logic rootBad;
   always_comb begin
      anyBankHit = 1'b0;
      ioBad = 1'b0;
      wideBad = 1'b0;
      prefBad = 1'b0;
      rootBad = 1'b0;
      for (int s = 0; s < NS; s++) begin
         anyBankHit |= slotHit[s] && (req.vfBank == (s >= `PBVF_VF_SLOT0));
         ioBad |= effCfg[s].en && effCfg[s].io && (mode_ff != PBVF_LEGACY || effCfg[s].is64);
         if (s != 0 && s != `PBVF_ROM_SLOT && s != `PBVF_VF_SLOT0) begin
            wideBad |= effCfg[s-1].en && effCfg[s-1].is64 && effCfg[s].en;
         end
         if (s != 5 && s != 12 && s != `PBVF_ROM_SLOT) begin
            prefBad |= mode_ff == PBVF_EP && effCfg[s].pref && !effCfg[s].is64;
         end
         if (s >= 2 && s <= 5) begin
            rootBad |= mode_ff == PBVF_ROOT && effCfg[s].en;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_io_legacy_only: assert property (!ioBad) else $error("io slot outside legacy mode");
   a_wide_upper_off: assert property (!wideBad) else $error("slot above wide slot enabled");
   a_pref_is_wide: assert property (!prefBad) else $error("prefetchable slot not 64-bit");
   a_root_two_slots: assert property (!rootBad) else $error("root port slot 2..5 enabled");
   a_rom_size_range: assert property (effCfg[`PBVF_ROM_SLOT].sizeLog2 >= `PBVF_SZ_2KB &&
      effCfg[`PBVF_ROM_SLOT].sizeLog2 <= `PBVF_SZ_4GB) else $error("rom size out of range");
   a_hit_follows_req: assert property (reqValid |=> reqHit == $past(anyBankHit))
      else $error("decode answer mismatch");
   a_no_req_no_hit: assert property (!reqValid |=> !reqHit) else $error("hit without request");
   a_pf_fixed_nums: assert property (fnValid && ari_ff && fnNum < 8'h04 |=>
      fnHit && !fnIsVf && fnOwner == $past(fnNum[1:0])) else $error("pf number wrong");
   a_noari_start: assert property (regRd && regAddr == `PBVF_OFF_STATUS && !ari_ff |=>
      regRdata[31:24] == `PBVF_VF_START_NOARI) else $error("non-ari start not 1");
   a_vf_in_range: assert property (fnValid && fnNum < 8'h04 |=> !fnIsVf)
      else $error("vf below number 4");

   c_mem_hit: cover property (reqValid && !req.vfBank ##1 reqHit);
   c_vf_hit: cover property (reqValid && req.vfBank ##1 reqHit);
   c_vf_lookup: cover property (fnValid ##1 fnIsVf);
   c_high_start: cover property (highStart_ff && layoutOk && totalVfs != 11'h000);
endmodule
`default_nettype wire

//--- bench/pbvf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pbvf_host_model
   import pbvf_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // command from the bench
   input wire logic go,
   input wire pbvf_req_s goReq,
   // request toward the device
   output logic reqValid,
   output pbvf_req_s req
);
   // one-cycle request; an idle bus flips so stale addresses never look valid
   always_ff @(posedge clk) begin
      reqValid <= go & ~rst;
      if (go) begin
         req <= goReq;
      end else begin
         req <= ~req;
      end
   end
endmodule
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbvf_cfg.svh"
module tb
   import pbvf_pkg::*;
;
   logic clk = 0;
   logic rst = 1;
   logic [8:0] regAddr = '0;
   logic [31:0] regWdata = '0;
   logic regWr = 0;
   logic regRd = 0;
   logic [31:0] regRdata;
   logic go = 0;
   pbvf_req_s goReq = '0;
   logic reqValid;
   pbvf_req_s req;
   logic reqHit;
   logic reqMergeOk;
   logic [3:0] reqSlot;
   logic fnValid = 0;
   logic [7:0] fnNum = '0;
   logic fnHit;
   logic fnIsVf;
   logic [1:0] fnOwner;
   logic [7:0] fnVfIdx;
   logic [15:0] fnDevId;
   int error_cnt = 0;
   int checked = 0;
   int cycles = 0;
   pbvf_top #(.MAX_VFS(252)) pbvf_top_i (.clk(clk), .rst(rst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
      .reqValid(reqValid), .req(req), .reqHit(reqHit), .reqSlot(reqSlot),
      .reqMergeOk(reqMergeOk), .fnValid(fnValid), .fnNum(fnNum), .fnHit(fnHit),
      .fnIsVf(fnIsVf), .fnOwner(fnOwner), .fnVfIdx(fnVfIdx), .fnDevId(fnDevId));
   pbvf_host_model pbvf_host_model_i (.clk(clk), .rst(rst), .go(go), .goReq(goReq),
      .reqValid(reqValid), .req(req));
   always #25 clk = ~clk;
   // the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input bit ok, input string msg);
      checked++;
      if (!ok) begin
         error_cnt++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr <= 1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWr <= 0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [8:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      regRd <= 1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 0;
      #1 chk((regRdata & m) === (e & m), "register read");
   endtask
   task automatic dec(input logic [63:0] a, input logic io, input logic h,
      input logic [3:0] s, input logic mg);
      @(posedge clk);
      go <= 1;
      goReq <= '{addr: a, io: io, vfBank: 1'b0};
      @(posedge clk);
      go <= 0;
      @(posedge clk);
      #1 chk(reqHit === h && reqSlot === s && reqMergeOk === mg, "decode");
   endtask
   task automatic fn(input logic [7:0] n, input logic h, input logic v,
      input logic [1:0] o, input logic [7:0] x, input logic [15:0] d);
      @(posedge clk);
      fnValid <= 1;
      fnNum <= n;
      @(posedge clk);
      fnValid <= 0;
      #1 chk(fnHit === h && fnIsVf === v && (!v || {fnOwner, fnVfIdx, fnDevId} === {o, x, d}),
         "lookup");
   endtask
   // legalized view of one slot under a given mode
   task automatic leg(input logic [1:0] md, input int s, input logic [31:0] c,
      input logic [31:0] e, input logic [31:0] m);
      wr(`PBVF_OFF_CTRL, {28'h000_0000, 2'b01, md});
      wr(`PBVF_OFF_BARCFG + 9'(4 * s), c);
      rd(`PBVF_OFF_EFF + 9'(4 * s), e, m);
   endtask
   task automatic t_reset();
      rd(`PBVF_OFF_STATUS, 32'h0400_0001, '1);
      rd(`PBVF_OFF_CAP, 32'h0000_0001, '1);
      rd(`PBVF_OFF_PAGE, 32'h0000_0001, '1);
      rd(9'h1FC, 32'h0000_0000, '1);
      $display("reset test done");
   endtask
   task automatic t_vfmap();
      wr(`PBVF_OFF_CTRL, 32'h0000_000C);
      wr(`PBVF_OFF_VFCNT, 32'h0000_0302);
      wr(9'h014, 32'hBEEF_03F2);
      wr(9'h024, 32'h0000_0013);
      rd(9'h014, 32'hBEEF_0302, '1);
      rd(9'h024, 32'h0000_0013, '1);
      rd(`PBVF_OFF_STATUS, 32'h4000_0501, '1);
      rd(`PBVF_OFF_DELTA, 32'h4243_4140, '1);
      fn(8'h41, 1, 1, 2'd0, 8'h01, 16'h0000);
      fn(8'h42, 1, 1, 2'd1, 8'h00, 16'hBEEF);
      fn(8'h44, 1, 1, 2'd1, 8'h02, 16'hBEEF);
      fn(8'h45, 0, 0, 2'd0, 8'h00, 16'h0000);
      fn(8'h03, 1, 0, 2'd0, 8'h00, 16'h0000);
      wr(`PBVF_OFF_VFCNT, 32'h0000_00C8);
      rd(`PBVF_OFF_STATUS, 32'h0000_0000, 32'h0000_0001);
      fn(8'h40, 0, 0, 2'd0, 8'h00, 16'h0000);
      wr(`PBVF_OFF_CTRL, 32'h0000_0004);
      rd(`PBVF_OFF_STATUS, 32'h0400_C801, '1);
      wr(`PBVF_OFF_CTRL, 32'h0000_0000);
      wr(`PBVF_OFF_VFCNT, 32'h0505_0509);
      rd(`PBVF_OFF_STATUS, 32'h0100_0701, '1);
      rd(`PBVF_OFF_DELTA, 32'h0000_0001, 32'h0000_00FF);
      fn(8'h07, 1, 1, 2'd0, 8'h06, 16'h0000);
      $display("function map test done");
   endtask
   task automatic t_decode();
      wr(`PBVF_OFF_CTRL, 32'h0000_0004);
      wr(`PBVF_OFF_BARCFG, 32'h0000_0C01);
      wr(`PBVF_OFF_BASE, 32'h1000_0000);
      dec(64'h1000_0ABC, 0, 1, 4'd0, 0);
      dec(64'h1000_0ABC, 1, 0, 4'd0, 0);
      dec(64'h1000_1000, 0, 0, 4'd0, 0);
      wr(9'h048, 32'h0000_140D);
      wr(9'h090, 32'h0010_0000);
      wr(9'h094, 32'h0000_0001);
      wr(9'h04C, 32'h0000_0C01);
      rd(9'h10C, 32'h0000_0000, 32'h0000_0001);
      dec(64'h1_0010_0123, 0, 1, 4'd2, 1);
      wr(`PBVF_OFF_BARCFG, 32'h0000_0000);
      dec(64'h1000_0ABC, 0, 0, 4'd0, 0);
      $display("decode test done");
   endtask
   task automatic t_legal();
      leg(2'd0, 0, 32'h0000_0401, 32'h0000_0701, '1);
      leg(2'd1, 0, 32'h0000_0401, 32'h0000_0401, '1);
      leg(2'd1, 0, 32'h0000_0203, 32'h0000_0403, '1);
      leg(2'd0, 0, 32'h0000_0403, 32'h0000_0000, 32'h0000_0001);
      leg(2'd0, 0, 32'h0000_2001, 32'h0000_1F01, '1);
      leg(2'd0, 4, 32'h0000_0C09, 32'h0000_0C0D, '1);
      // slot 4 is now wide, so slot 5 stays narrow and is taken as its upper half
      leg(2'd0, 5, 32'h0000_0C09, 32'h0000_0C08, '1);
      leg(2'd0, 6, 32'h0000_2101, 32'h0000_2001, '1);
      leg(2'd0, 7, 32'h0000_2705, 32'h0000_2605, '1);
      leg(2'd2, 2, 32'h0000_0C01, 32'h0000_0000, 32'h0000_0001);
      $display("legalize test done");
   endtask
   // reset held two cycles, then each scenario in turn
   initial begin
      repeat (2) @(posedge clk);
      rst <= 0;
      t_reset();
      t_vfmap();
      t_decode();
      t_legal();
      print_verdict();
   end
endmodule
`default_nettype wire
